// ==== src/uet_pkg.sv ====
package uet_pkg;

   // ---------------------------------------------------------------
   // endpoint geometry
   // ---------------------------------------------------------------
   localparam logic [2:0] EP_COUNT = 3'h6;        // endpoints on the device
   localparam logic [7:0] DUAL_MAP = 8'h36;       // endpoints with two banks
   localparam logic [7:0] LARGE_MAP = 8'h30;      // endpoints with large payload
   localparam logic [10:0] SIZE_SMALL = 11'h040;  // 64-byte payload limit
   localparam logic [10:0] SIZE_LARGE = 11'h200;  // 512-byte payload limit
   localparam int BUF_DEPTH = 512;                // local payload buffer
   localparam int PTR_W = 9;                      // buffer index width
   localparam int CNT_W = 11;                     // byte count width

   // ---------------------------------------------------------------
   // device register map, reached through the device apb port
   // ---------------------------------------------------------------
   localparam logic [31:0] DEV_CSR_BASE = 32'h0000_0030; // status/control words
   localparam logic [31:0] DEV_FDR_BASE = 32'h0000_0050; // fifo data ports
   localparam int CSR_TX_COMPLETE = 0;            // set by device on host ack
   localparam int CSR_RX_BANK0 = 1;               // bank 0 holds an out payload
   localparam int CSR_SETUP = 2;                  // setup packet received
   localparam int CSR_TX_READY = 4;               // in packet handed to device
   localparam int CSR_CNT_LSB = 16;               // received byte count
   localparam int CSR_CNT_MSB = 26;
   // writing one to a device-set flag leaves it, writing zero clears it
   localparam logic [31:0] CSR_KEEP = 32'h0000_0007;
   localparam logic [31:0] CSR_READY_MASK = 32'h0000_0010;
   localparam logic [31:0] CSR_CMP_MASK = 32'h0000_0001;
   localparam logic [31:0] CSR_RX_MASK = 32'h0000_0002;
   localparam logic [31:0] CSR_SETUP_MASK = 32'h0000_0004;

   // ---------------------------------------------------------------
   // controller registers, reached by software over apb
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;       // command start and abort
   localparam logic [7:0] REG_LEN = 8'h04;        // in payload length
   localparam logic [7:0] REG_STATUS = 8'h08;     // busy, done, error, counts
   localparam logic [7:0] REG_BUF_PTR = 8'h0C;    // payload buffer pointer
   localparam logic [7:0] REG_BUF_DATA = 8'h10;   // payload byte window
   localparam int CTRL_START = 0;
   localparam int CTRL_CMD_LSB = 1;
   localparam int CTRL_CMD_MSB = 2;
   localparam int CTRL_EP_LSB = 4;
   localparam int CTRL_EP_MSB = 6;
   localparam int CTRL_ISO = 8;
   localparam int CTRL_ABORT = 9;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_ERR = 2;
   localparam int ST_OWE_LSB = 8;
   localparam int ST_CNT_LSB = 16;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_IN = 2'h0,       // load and arm one in packet
      CMD_OUT = 2'h1,      // collect one out payload
      CMD_SETUP = 2'h2,    // collect one setup packet
      CMD_IN_FINISH = 2'h3 // retire the last in packet
   } uet_cmd_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_POLL_RDY = 4'h1,
      S_FILL = 4'h2,
      S_POLL_CMP = 4'h3,
      S_ARM = 4'h4,
      S_CLR_CMP = 4'h5,
      S_POLL_RX = 4'h6,
      S_DRAIN = 4'h7,
      S_CLR_RX = 4'h8
   } uet_state_t;

   typedef enum logic [1:0] {
      M_IDLE = 2'h0,
      M_SETUP = 2'h1,
      M_ACCESS = 2'h2
   } uet_mstate_t;

   // ---------------------------------------------------------------
   // endpoint decoding
   // ---------------------------------------------------------------
   function automatic logic ep_is_dual(input logic [2:0] ep);
      return (ep < EP_COUNT) && DUAL_MAP[ep];
   endfunction

   function automatic logic [10:0] ep_max_size(input logic [2:0] ep);
      return LARGE_MAP[ep] ? SIZE_LARGE : SIZE_SMALL;
   endfunction

   function automatic logic [31:0] csr_addr(input logic [2:0] ep);
      return DEV_CSR_BASE + {27'h0, ep, 2'h0};
   endfunction

   function automatic logic [31:0] fdr_addr(input logic [2:0] ep);
      return DEV_FDR_BASE + {27'h0, ep, 2'h0};
   endfunction

endpackage

// ==== src/uet_apb_master.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------
// single-transfer apb master toward the device registers
// -----------------------------------------------------------------
module uet_apb_master (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // request side, held until ack
   input wire logic req,
   input wire logic req_write,
   input wire logic [31:0] req_addr,
   input wire logic [31:0] req_wdata,
   output logic ack,
   // apb master pins
   output logic m_psel,
   output logic m_penable,
   output logic [31:0] m_paddr,
   output logic m_pwrite,
   output logic [31:0] m_pwdata,
   input wire logic m_pready
);

   uet_pkg::uet_mstate_t st_ff; // transfer phase

   // completion is the edge where pready is seen in the access phase
   assign ack = (st_ff == uet_pkg::M_ACCESS) && m_pready;

   // phase sequencing; the request is copied at setup so it stays stable
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         st_ff <= uet_pkg::M_IDLE;
         m_psel <= 1'b0;
         m_penable <= 1'b0;
         m_paddr <= 32'h0;
         m_pwrite <= 1'b0;
         m_pwdata <= 32'h0;
      end
      else
      begin
         unique case (st_ff)
            uet_pkg::M_IDLE:
            begin
               // take a new request
               if (req)
               begin
                  m_psel <= 1'b1;
                  m_paddr <= req_addr;
                  m_pwrite <= req_write;
                  m_pwdata <= req_wdata;
                  st_ff <= uet_pkg::M_SETUP;
               end
            end
            uet_pkg::M_SETUP:
            begin
               m_penable <= 1'b1;
               st_ff <= uet_pkg::M_ACCESS;
            end
            uet_pkg::M_ACCESS:
            begin
               // wait as long as the device stretches pready
               if (m_pready)
               begin
                  m_psel <= 1'b0;
                  m_penable <= 1'b0;
                  st_ff <= uet_pkg::M_IDLE;
               end
            end
            default:
               st_ff <= uet_pkg::M_IDLE;
         endcase
      end
   end

endmodule

// ==== src/uet_host_ctrl.sv ====
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE1: control transfers only on single-bank endpoints
// RULE2: isochronous transfers only on dual-bank endpoints
// RULE3: device acknowledges setup packets by itself
// RULE4: device flags setup and holds endpoint interrupt
// RULE5: read whole setup packet before clearing flag
// RULE6: device answers status in with empty DATA1
// RULE7: host sends empty out packet for status
// RULE8: single bank: wait until tx_packet_ready clear
// RULE9: load bytes one by one, then arm
// RULE10: device flags tx_complete on host ack
// RULE11: clear tx_complete after arming next packet
// RULE12: device swaps banks between packets on ping-pong
// RULE13: dual bank: fill second bank without waiting
// RULE14: after tx_complete, arm second bank again
// RULE15: device NAKs in tokens with nothing armed
// RULE16: device NAKs out while processor owns fifo
// RULE17: device sets rx_bank0_full after storing payload
// RULE18: device reports rx_byte_count, firmware drains fifo
// RULE19: clear rx_bank0_full only after draining bank
// RULE20: no fifo access after clearing rx_bank0_full
// RULE21: six endpoints, banks and sizes fixed per endpoint
// RULE22: device runs register and bus clocks apart
// RULE23: each fifo access moves one byte
module uet_host_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // software apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // apb master toward the device
   output logic m_psel,
   output logic m_penable,
   output logic [31:0] m_paddr,
   output logic m_pwrite,
   output logic [31:0] m_pwdata,
   input wire logic [31:0] m_prdata,
   input wire logic m_pready
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   uet_pkg::uet_state_t state_ff, nxt_state; // command sequencer
   uet_pkg::uet_cmd_t cmd_ff;                // command in progress
   logic [2:0] ep_ff;                        // endpoint in progress
   logic dual_ff;                            // endpoint has two banks
   logic [10:0] len_ff;                      // in payload length
   logic [10:0] idx_ff;                      // byte index in transfer
   logic [10:0] cnt_ff;                      // last received byte count
   logic [5:0] owe_ff;                       // per endpoint: completion owed
   logic armed_ff;                           // armed during this command; a finish sets it at start
   logic cmp_seen_ff;                        // completion seen this command
   logic done_ff;                            // sticky: command started or finished
   logic err_ff;                             // sticky: command refused
   logic abort_ff;                           // abort pending at next poll
   logic [8:0] buf_ptr_ff;                   // software buffer pointer
   logic [7:0] buf_mem [uet_pkg::BUF_DEPTH]; // payload buffer

   // ---------------------------------------------------------------
   // software bus decode
   // ---------------------------------------------------------------
   wire sw_acc = psel && penable;
   wire sw_wr = sw_acc && pwrite;
   wire hit_ctrl = paddr[7:0] == uet_pkg::REG_CTRL;
   wire hit_len = paddr[7:0] == uet_pkg::REG_LEN;
   wire hit_stat = paddr[7:0] == uet_pkg::REG_STATUS;
   wire hit_ptr = paddr[7:0] == uet_pkg::REG_BUF_PTR;
   wire hit_data = paddr[7:0] == uet_pkg::REG_BUF_DATA;
   wire hit_any = (paddr[31:8] == 24'h0) &&
                  (hit_ctrl || hit_len || hit_stat || hit_ptr || hit_data);
   wire idle = state_ff == uet_pkg::S_IDLE;

   // registers answer at once; unmapped words report an error
   assign pready = 1'b1;
   assign pslverr = sw_acc && !hit_any;

   // ---------------------------------------------------------------
   // command acceptance
   // ---------------------------------------------------------------
   wire start = sw_wr && hit_any && hit_ctrl && pwdata[uet_pkg::CTRL_START] && idle;
   wire abort_set = sw_wr && hit_any && hit_ctrl && pwdata[uet_pkg::CTRL_ABORT];
   wire [1:0] new_cmd_bits = pwdata[uet_pkg::CTRL_CMD_MSB:uet_pkg::CTRL_CMD_LSB];
   wire [2:0] new_ep = pwdata[uet_pkg::CTRL_EP_MSB:uet_pkg::CTRL_EP_LSB];
   wire new_dual = uet_pkg::ep_is_dual(new_ep);
   wire new_in = new_cmd_bits == uet_pkg::CMD_IN;
   // refuse what the endpoint cannot carry
   wire bad_ep = new_ep >= uet_pkg::EP_COUNT;                                 // see RULE21
   wire bad_ctl = (new_cmd_bits == uet_pkg::CMD_SETUP) && new_dual;           // see RULE1
   wire bad_iso = pwdata[uet_pkg::CTRL_ISO] && !new_dual;                     // see RULE2
   wire bad_len = new_in && (len_ff > uet_pkg::ep_max_size(new_ep));          // see RULE21
   wire refuse = bad_ep || bad_ctl || bad_iso || bad_len;
   wire go = start && !refuse;

   // ---------------------------------------------------------------
   // device-side events
   // ---------------------------------------------------------------
   logic ack; // device transfer completed this cycle
   wire owe_cur = owe_ff[ep_ff];
   wire ready_bit = m_prdata[uet_pkg::CSR_TX_READY];
   wire cmp_bit = m_prdata[uet_pkg::CSR_TX_COMPLETE];
   wire rx_bit = (cmd_ff == uet_pkg::CMD_SETUP) ? m_prdata[uet_pkg::CSR_SETUP] :
                 m_prdata[uet_pkg::CSR_RX_BANK0];
   wire [10:0] rx_cnt_in = m_prdata[uet_pkg::CSR_CNT_MSB:uet_pkg::CSR_CNT_LSB];
   wire [10:0] xfer_len = (state_ff == uet_pkg::S_DRAIN) ? cnt_ff : len_ff;
   wire last_byte = (idx_ff + 11'h001) == xfer_len;
   wire is_poll = (state_ff == uet_pkg::S_POLL_RDY) || (state_ff == uet_pkg::S_POLL_CMP) ||
                  (state_ff == uet_pkg::S_POLL_RX);
   // a second bank may be loaded while the first is still armed; the
   // completion of the first is then awaited before arming again
   wire fill_to_cmp = owe_cur && dual_ff;                                     // see RULE14
   uet_pkg::uet_state_t fill_next;
   assign fill_next = fill_to_cmp ? uet_pkg::S_POLL_CMP : uet_pkg::S_ARM;

   // ---------------------------------------------------------------
   // sequencer next state
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         uet_pkg::S_IDLE:
         begin
            if (go)
            begin
               if (new_cmd_bits == uet_pkg::CMD_IN)
                  nxt_state = uet_pkg::S_POLL_RDY;
               else if (new_cmd_bits == uet_pkg::CMD_IN_FINISH)
                  nxt_state = owe_ff[new_ep] ? uet_pkg::S_POLL_CMP : uet_pkg::S_IDLE;
               else
                  nxt_state = uet_pkg::S_POLL_RX;
            end
         end
         uet_pkg::S_POLL_RDY:
         begin
            // one bank: the fifo is free only once the device took it
            if (ack && (dual_ff || !ready_bit))                               // see RULE8, RULE13
               nxt_state = (len_ff == 11'h000) ? fill_next : uet_pkg::S_FILL;
         end
         uet_pkg::S_FILL:
         begin
            if (ack && last_byte)
               nxt_state = fill_next;
         end
         uet_pkg::S_POLL_CMP:
         begin
            // the device keeps nak-ing until armed; we simply keep polling
            if (ack && cmp_bit)                                               // see RULE10, RULE15
               nxt_state = armed_ff ? uet_pkg::S_CLR_CMP : uet_pkg::S_ARM;
         end
         uet_pkg::S_ARM:
         begin
            if (ack)
               nxt_state = !owe_cur ? uet_pkg::S_IDLE :
                           (cmp_seen_ff ? uet_pkg::S_CLR_CMP : uet_pkg::S_POLL_CMP);
         end
         uet_pkg::S_CLR_CMP:
         begin
            if (ack)
               nxt_state = uet_pkg::S_IDLE;
         end
         uet_pkg::S_POLL_RX:
         begin
            if (ack && rx_bit)                                                // see RULE4, RULE17
               nxt_state = (rx_cnt_in == 11'h000) ? uet_pkg::S_CLR_RX :       // see RULE7
                           uet_pkg::S_DRAIN;
         end
         uet_pkg::S_DRAIN:
         begin
            // the flag is released only after the last byte is out
            if (ack && last_byte)                                             // see RULE5, RULE19
               nxt_state = uet_pkg::S_CLR_RX;
         end
         uet_pkg::S_CLR_RX:
         begin
            // after this write the fifo is never touched again
            if (ack)                                                          // see RULE20
               nxt_state = uet_pkg::S_IDLE;
         end
         default:
            nxt_state = uet_pkg::S_IDLE;
      endcase
      // an abort only lands on a miss, so no transfer is cut short
      if (is_poll && ack && abort_ff && (nxt_state == state_ff))
         nxt_state = uet_pkg::S_IDLE;
   end

   // ---------------------------------------------------------------
   // device request composition
   // ---------------------------------------------------------------
   wire dev_req = !idle;
   wire dev_write = (state_ff == uet_pkg::S_FILL) || (state_ff == uet_pkg::S_ARM) ||
                    (state_ff == uet_pkg::S_CLR_CMP) || (state_ff == uet_pkg::S_CLR_RX);
   wire to_fifo = (state_ff == uet_pkg::S_FILL) || (state_ff == uet_pkg::S_DRAIN);
   wire [31:0] dev_addr = to_fifo ? uet_pkg::fdr_addr(ep_ff) : uet_pkg::csr_addr(ep_ff);
   // keep tx_packet_ready high while clearing a completion of a re-arm
   wire [31:0] keep_ready = (cmd_ff == uet_pkg::CMD_IN) ? uet_pkg::CSR_READY_MASK : 32'h0;
   wire [31:0] rx_clear = (cmd_ff == uet_pkg::CMD_SETUP) ? uet_pkg::CSR_SETUP_MASK :
                          uet_pkg::CSR_RX_MASK;
   logic [31:0] dev_wdata;
   always_comb
   begin
      unique case (state_ff)
         uet_pkg::S_FILL: dev_wdata = {24'h0, buf_mem[idx_ff[8:0]]};         // see RULE9, RULE23
         uet_pkg::S_ARM: dev_wdata = uet_pkg::CSR_KEEP | uet_pkg::CSR_READY_MASK; // see RULE9
         uet_pkg::S_CLR_CMP:
            dev_wdata = (uet_pkg::CSR_KEEP & ~uet_pkg::CSR_CMP_MASK) | keep_ready; // see RULE11
         uet_pkg::S_CLR_RX: dev_wdata = uet_pkg::CSR_KEEP & ~rx_clear;        // see RULE19
         default: dev_wdata = 32'h0;
      endcase
   end

   uet_apb_master u_master (
      .clk(clk),
      .srst(srst),
      .req(dev_req),
      .req_write(dev_write),
      .req_addr(dev_addr),
      .req_wdata(dev_wdata),
      .ack(ack),
      .m_psel(m_psel),
      .m_penable(m_penable),
      .m_paddr(m_paddr),
      .m_pwrite(m_pwrite),
      .m_pwdata(m_pwdata),
      .m_pready(m_pready)
   );

   // ---------------------------------------------------------------
   // sequencer registers
   // ---------------------------------------------------------------
   wire finish = (go || !idle) && (nxt_state == uet_pkg::S_IDLE);

   // state and command capture
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_ff <= uet_pkg::S_IDLE;
         cmd_ff <= uet_pkg::CMD_IN;
         ep_ff <= 3'h0;
         dual_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (go)
         begin
            cmd_ff <= uet_pkg::uet_cmd_t'(new_cmd_bits);
            ep_ff <= new_ep;
            dual_ff <= new_dual;
         end
      end
   end

   // byte index and received count
   always_ff @(posedge clk)
   begin
      if (srst || !to_fifo)
         idx_ff <= 11'h000;
      else if (ack)
         idx_ff <= idx_ff + 11'h001;                                          // see RULE23
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         cnt_ff <= 11'h000;
      else if (state_ff == uet_pkg::S_POLL_RX && ack && rx_bit)
         cnt_ff <= rx_cnt_in;                                                 // see RULE18
   end

   // completion bookkeeping per command and per endpoint
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         armed_ff <= 1'b0;
         cmp_seen_ff <= 1'b0;
      end
      else if (go)
      begin
         // a finish arms nothing, so its completion is cleared at once
         armed_ff <= new_cmd_bits == uet_pkg::CMD_IN_FINISH;
         cmp_seen_ff <= 1'b0;
      end
      else
      begin
         if (state_ff == uet_pkg::S_ARM && ack)
            armed_ff <= 1'b1;
         if (state_ff == uet_pkg::S_POLL_CMP && ack && cmp_bit)
            cmp_seen_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         owe_ff <= 6'h00;
      else if (state_ff == uet_pkg::S_ARM && ack)
         owe_ff[ep_ff] <= 1'b1;
      else if (state_ff == uet_pkg::S_CLR_CMP && ack)
         owe_ff[ep_ff] <= cmd_ff != uet_pkg::CMD_IN_FINISH;                   // see RULE11
   end

   // sticky flags; a set in the clearing cycle wins
   wire sw_stat_wr = sw_wr && hit_any && hit_stat;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         abort_ff <= 1'b0;
      end
      else
      begin
         done_ff <= finish || start || (done_ff && !(sw_stat_wr && pwdata[uet_pkg::ST_DONE]));
         err_ff <= (start && refuse) ||
                   (err_ff && !(sw_stat_wr && pwdata[uet_pkg::ST_ERR]));
         abort_ff <= abort_set || (abort_ff && !idle);
      end
   end

   // ---------------------------------------------------------------
   // payload buffer and software registers
   // ---------------------------------------------------------------
   wire sw_data = sw_acc && hit_any && hit_data && idle;

   always_ff @(posedge clk)
   begin
      if (srst)
         len_ff <= 11'h000;
      else if (sw_wr && hit_any && hit_len && idle)
         len_ff <= pwdata[10:0];
   end

   // pointer moves on every byte access while idle, read or write
   always_ff @(posedge clk)
   begin
      if (srst)
         buf_ptr_ff <= 9'h000;
      else if (sw_wr && hit_any && hit_ptr && idle)
         buf_ptr_ff <= pwdata[8:0];
      else if (sw_data)
         buf_ptr_ff <= buf_ptr_ff + 9'h001;
   end

   // received bytes land at their index; software writes only when idle
   always_ff @(posedge clk)
   begin
      if (state_ff == uet_pkg::S_DRAIN && ack)
         buf_mem[idx_ff[8:0]] <= m_prdata[7:0];                               // see RULE18
      else if (sw_data && pwrite)
         buf_mem[buf_ptr_ff] <= pwdata[7:0];
   end

   // read mux
   wire [31:0] ctrl_rd = {23'h0, dual_ff, 1'b0, ep_ff, 1'b0, cmd_ff, 1'b0};
   wire [31:0] stat_rd = {5'h0, cnt_ff, 2'h0, owe_ff, 5'h0, err_ff, done_ff, !idle};
   assign prdata = !hit_any ? 32'h0 :
                   hit_ctrl ? ctrl_rd :
                   hit_len ? {21'h0, len_ff} :
                   hit_stat ? stat_rd :
                   hit_ptr ? {23'h0, buf_ptr_ff} :
                   {24'h0, buf_mem[buf_ptr_ff]};

endmodule

// ==== verif/uet_chk_sva.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// port checks on the controller
// ---------------------------------------------
module uet_chk (
   // watched ports
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic m_psel,
   input wire logic m_penable,
   input wire logic [31:0] m_paddr,
   input wire logic m_pwrite,
   input wire logic [31:0] m_pwdata,
   input wire logic m_pready
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // device write to a status word; fifo ports sit higher
   wire csr_w = m_psel & m_pwrite & (m_paddr < 32'h00000048);
   a_err_access: assert property (pslverr |-> psel & penable) else $error("stray error");
   a_bad_addr: assert property (psel & penable & (paddr > 32'h10) |-> pslverr)
      else $error("no slave error");
   a_setup_phase: assert property (m_psel & !m_penable |=> m_penable)
      else $error("no access phase");
   a_hold_req: assert property (m_psel & !(m_penable & m_pready) |=> $stable(m_paddr)
      & $stable(m_pwdata) & $stable(m_pwrite)) else $error("request moved");
   a_gap_after: assert property (m_psel & m_penable & m_pready |=> !m_psel)
      else $error("back to back");
   a_byte_wide: assert property (m_psel & m_pwrite & (m_paddr >= 32'h50)
      |-> m_pwdata[31:8] == 0) else $error("fifo not byte");
   a_one_clear: assert property (csr_w |-> $countones(~m_pwdata[2:0]) <= 1)
      else $error("two flags cleared");
   a_reset_idle: assert property (disable iff (1'b0) srst |=> !m_psel & !m_penable)
      else $error("busy in reset");
endmodule
bind uet_host_ctrl uet_chk chk (.*);

// ==== verif/uet_dev.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// device model: one flag set for all endpoints
// ---------------------------------------------
module uet_dev (
   // clock, reset, host packets (0 out, 1 setup)
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] go,
   input wire logic m_psel,
   input wire logic m_penable,
   input wire logic [31:0] m_paddr,
   input wire logic m_pwrite,
   input wire logic [31:0] m_pwdata,
   output logic [31:0] m_prdata,
   output logic m_pready
);
   logic cmp_ff, rx_ff, su_ff, rdy_ff, slow_ff;
   logic [7:0] ptr_ff;
   wire hit = m_psel & m_penable & m_pready;
   wire fdr = m_paddr >= 32'h50; // fifo ports sit from 0x50 up
   wire csr_w = hit & ~fdr & m_pwrite;
   // slow on purpose, as if crossing to the bus clock: ready every other cycle
   assign m_pready = slow_ff;
   // byte count is always two
   assign m_prdata = fdr ? {24'h0, 8'hA0 + ptr_ff} :
      {5'h0, 11'h002, 11'h000, rdy_ff, 1'h0, su_ff, rx_ff, cmp_ff};
   // host acks an armed packet next cycle, naks while none is armed
   always_ff @(posedge clk)
   begin
      slow_ff <= ~slow_ff & ~srst;
      rdy_ff <= ~srst & csr_w & m_pwdata[4];
      cmp_ff <= ~srst & (csr_w ? cmp_ff & m_pwdata[0] : cmp_ff | rdy_ff);
      rx_ff <= ~srst & (csr_w ? rx_ff & m_pwdata[1] : rx_ff | go[0]);
      su_ff <= ~srst & (csr_w ? su_ff & m_pwdata[2] : su_ff | go[1]);
      ptr_ff <= (srst | csr_w) ? 8'h00 : ptr_ff + {7'h0, hit & fdr};
   end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// bench: software apb side, device model far side
// ---------------------------------------------
module testbench;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd, m_paddr, m_pwdata, m_prdata;
   logic m_psel, m_penable, m_pwrite, m_pready;
   logic [1:0] go = 0;
   int n_fail = 0, n_compared = 0;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] x; logic [31:0] e;} uet_row_t;
   uet_row_t rows [4] = '{'{8'h0C, 32'h3FF, 32'h1FF, 0}, '{8'h04, 32'h40, 32'h40, 0},
      '{8'h14, 32'h5, 32'h0, 1}, '{8'h0C, 32'h0, 32'h0, 0}};
   logic [31:0] bad [3] = '{32'h15, 32'h101, 32'h61};
   uet_host_ctrl dut (.*);
   uet_dev dev (.*);
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one apb transfer; pready is sampled at each edge of the access phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      for (int i = 0; i < 9 && pready !== 1'h1; i++)
         @(posedge clk);
      if (pready !== 1'h1)
      begin
         n_fail++;
         $display("Error %0t: no pready", $time);
         finish_test;
      end
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // start a command, then poll status until not busy
   task automatic run(input logic [31:0] c);
      bus(1, 8'h00, c);
      for (int i = 0; i < 500; i++)
      begin
         bus(0, 8'h08, 0);
         if (rd[0] === 1'h0)
            break;
      end
      chk(rd & 32'h1, 32'h0);
      if (rd[0] !== 1'h0)
         finish_test;
   endtask
   task automatic finish_test;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 0;
      foreach (rows[i])
      begin
         bus(1, rows[i].a, rows[i].w);
         bus(0, rows[i].a, 0);
         chk(rd, rows[i].x);
         chk({31'h0, er}, rows[i].e);
         $display("row %0d done", i);
      end
      bus(1, 8'h10, 32'h11);
      bus(1, 8'h10, 32'h22);
      bus(1, 8'h04, 32'h2);
      run(32'h01);
      chk(rd & 32'h100, 32'h100);
      run(32'h07);
      chk(rd & 32'h100, 32'h0);
      go <= 2'h1;
      run(32'h03);
      chk(rd & 32'h7FF0000, 32'h20000);
      bus(1, 8'h0C, 0);
      bus(0, 8'h10, 0);
      chk(rd, 32'hA0);
      go <= 2'h2;
      run(32'h05);
      chk(rd & 32'h7FF0000, 32'h20000);
      foreach (bad[i])
      begin
         run(bad[i]);
         chk(rd & 32'h4, 32'h4);
         bus(1, 8'h08, 32'h6);
      end
      go <= 2'h0;
      srst <= 1;
      @(posedge clk);
      srst <= 0;
      bus(0, 8'h04, 0);
      chk(rd, 32'h0);
      bus(1, 8'h00, 32'h03);
      run(32'h200);
      chk(rd & 32'h6, 32'h2);
      run(32'h01);
      chk(rd & 32'h100, 32'h100);
      run(32'h111);
      run(32'h111);
      chk(rd & 32'h304, 32'h300);
      $display("hand tests done");
      finish_test;
   end
endmodule
